// [common/csd_regs.svh]
// Notes on behaviour
// - Interrogate any card inserted into an unpowered socket before power.
// - Decode both card-detect and both voltage-sense pins together.
// - Both detects grounded means 16-bit card; sense pins give voltages.
// - A detect strapped to a sense pin means CardBus; strap gives voltages.
// - Card control bit 6 enables zoomed video.
// - Zoomed video floats address lines 25..4, keeps 3..0 driven.
// - Active-low video select and active-high status outputs follow zoomed video.
// - Present state bit 27 shows platform video support.
// - Writing force event bit 27 sets platform video support.
// - Socket control bit 11 shows video in use.
// - Socket control bit 10 reads 1 when standard video model exists.
// - Socket control bit 9 enables or disables zoomed video.
// - Diagnostic bit 0 at 1 disables the standard video model.
// - With the standard model on, both enable paths still work.
// - Internal ring oscillator allows power down and interrogation alone.
// - System control bit 27 enables ring oscillator, set after reset.
// - Status-change pin pullup for 16-bit card, pulldown for CardBus.
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

// config space offsets
`define CSD_SYS_CTRL_OFF 8'h80
`define CSD_CARD_CTRL_OFF 8'h91
`define CSD_DIAG_OFF 8'h93
// socket space offsets
`define CSD_PRESENT_OFF 8'h08
`define CSD_FORCE_OFF 8'h0C
`define CSD_SOCK_CTRL_OFF 8'h10

// field positions
`define CSD_RING_OSC_BIT 27
`define CSD_LEGACY_ZV_BIT 6
`define CSD_STD_DIS_BIT 0
`define CSD_ZV_SUPPORT_BIT 27
`define CSD_ZV_ACTIVE_BIT 11
`define CSD_STD_PRESENT_BIT 10
`define CSD_STD_ZV_EN_BIT 9
`define CSD_PS_CD_LSB 0
`define CSD_PS_16BIT_BIT 4
`define CSD_PS_CB_BIT 5
`define CSD_PS_DONE_BIT 6
`define CSD_PS_BADCARD_BIT 7
`define CSD_PS_VOLT_LSB 10

// reset values
`define CSD_RING_OSC_RST 1'b1

// timing
`define CSD_CLK_NS 10
`define CSD_SETTLE_NS 1000
`define CSD_SETTLE_CYC ((`CSD_SETTLE_NS + `CSD_CLK_NS - 1) / `CSD_CLK_NS)

`endif

// [common/csd_pkg.sv]
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_ST_EMPTY,
    CSD_ST_OPEN,
    CSD_ST_DRV_A,
    CSD_ST_DRV_B,
    CSD_ST_DONE
  } csd_state_t;

  typedef enum logic [1:0] {
    CSD_CARD_NONE,
    CSD_CARD_16BIT,
    CSD_CARD_CARDBUS,
    CSD_CARD_UNKNOWN
  } csd_card_t;
endpackage

// [verilog/csd_ctrl.sv]
`timescale 1ns/1ps
`include "csd_regs.svh"

module csd_ctrl
  import csd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic reg_space,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // card detect and voltage sense pins
  input wire logic card_detect_a,
  input wire logic card_detect_b,
  input wire logic voltage_sense_a_in,
  output logic voltage_sense_a_out,
  output logic voltage_sense_a_oe,
  input wire logic voltage_sense_b_in,
  output logic voltage_sense_b_out,
  output logic voltage_sense_b_oe,
  // card status
  output logic card_power_permit,
  output logic stschg_pullup_en,
  output logic stschg_pulldown_en,
  // zoomed video
  output logic [25:0] card_addr_oe,
  output logic video_switch_select_n,
  output logic video_path_status_out,
  // clocking
  output logic ring_osc_enable
);

  localparam logic [7:0] SETTLE_MAX = 8'(`CSD_SETTLE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a level counts once stages two and three agree

  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;

  assign pin_raw = {voltage_sense_b_in, voltage_sense_a_in,
                    card_detect_b, card_detect_a};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrogation sequence

  csd_state_t state_q;
  csd_state_t state_d;
  logic [7:0] cnt_q;
  logic [3:0] smp0_q;
  logic [1:0] cda_q;
  logic [1:0] cdb_q;
  csd_card_t type_q;
  csd_card_t dec_type;
  logic [3:0] volt_q;
  logic [3:0] dec_volt;

  wire card_gone = pin_q[0] & pin_q[1];
  wire settled = (cnt_q == SETTLE_MAX);

  // insertion into the empty socket always starts a fresh interrogation
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSD_ST_EMPTY: state_d = card_gone ? CSD_ST_EMPTY : CSD_ST_OPEN;
      CSD_ST_OPEN: state_d = settled ? CSD_ST_DRV_A : CSD_ST_OPEN;
      CSD_ST_DRV_A: state_d = settled ? CSD_ST_DRV_B : CSD_ST_DRV_A;
      CSD_ST_DRV_B: state_d = settled ? CSD_ST_DONE : CSD_ST_DRV_B;
      CSD_ST_DONE: state_d = CSD_ST_DONE;
      default: state_d = CSD_ST_EMPTY;
    endcase
    if (card_gone) begin
      state_d = CSD_ST_EMPTY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= CSD_ST_EMPTY;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  // each sense pin is pulled low in turn to find which detect it is tied to
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      smp0_q <= 4'hF;
      cda_q <= 2'h3;
      cdb_q <= 2'h3;
    end else if (settled) begin
      if (state_q == CSD_ST_OPEN) begin
        smp0_q <= pin_q;
      end
      if (state_q == CSD_ST_DRV_A) begin
        cda_q <= pin_q[1:0];
      end
      if (state_q == CSD_ST_DRV_B) begin
        cdb_q <= pin_q[1:0];
      end
    end
  end

  assign voltage_sense_a_out = 1'b0;
  assign voltage_sense_b_out = 1'b0;
  assign voltage_sense_a_oe = (state_q == CSD_ST_DRV_A);
  assign voltage_sense_b_oe = (state_q == CSD_ST_DRV_B);

  ////////////////////////////////////////////////////////////////////////////
  // card type decode; volt bits are Y, X, 3.3 V, 5 V from high to low

  wire cd_a_hi = smp0_q[0];
  wire cd_b_hi = smp0_q[1];
  wire st_aa = cd_a_hi & ~cda_q[0];
  // the last probe is decoded live: cdb_q only takes it at the done edge
  wire [1:0] cdb_now = (state_q == CSD_ST_DRV_B) ? pin_q[1:0] : cdb_q;
  wire st_ab = cd_a_hi & ~cdb_now[0];
  wire st_ba = cd_b_hi & ~cda_q[1];
  wire st_bb = cd_b_hi & ~cdb_now[1];
  wire [7:0] key = {cd_b_hi, cd_a_hi, st_bb, st_ba, st_ab, st_aa,
                    smp0_q[3], smp0_q[2]};

  always_comb begin
    dec_volt = 4'h0;
    casez (key)
      8'b00????11: dec_volt = 4'h1;
      8'b00????10: dec_volt = 4'h3;
      8'b00????00: dec_volt = 4'h7;
      8'b00????01: dec_volt = 4'h4;
      8'b01??011?: dec_volt = 4'h2;
      8'b01??10?1: dec_volt = 4'hC;
      8'b1010???0: dec_volt = 4'h6;
      8'b1010???1: dec_volt = 4'h4;
      8'b1001??0?: dec_volt = 4'hE;
      8'b1001??1?: dec_volt = 4'h8;
      default: dec_volt = 4'h0;
    endcase
  end

  // an empty voltage set marks a reserved or undecodable combination
  always_comb begin
    dec_type = CSD_CARD_CARDBUS;
    if (dec_volt == 4'h0) begin
      dec_type = CSD_CARD_UNKNOWN;
    end else if (key[7:6] == 2'b00) begin
      dec_type = CSD_CARD_16BIT;
    end
  end

  wire enter_done = (state_q == CSD_ST_DRV_B) && (state_d == CSD_ST_DONE);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      type_q <= CSD_CARD_NONE;
      volt_q <= 4'h0;
    end else if (state_d == CSD_ST_EMPTY) begin
      type_q <= CSD_CARD_NONE;
      volt_q <= 4'h0;
    end else if (enter_done) begin
      type_q <= dec_type;
      volt_q <= dec_volt;
    end
  end

  wire good_card = (type_q == CSD_CARD_16BIT) ||
                   (type_q == CSD_CARD_CARDBUS);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  localparam int CC_LANE = int'(`CSD_CARD_CTRL_OFF & 8'h03);
  localparam int DG_LANE = int'(`CSD_DIAG_OFF & 8'h03);

  logic ring_osc_q;
  logic legacy_video_enable;
  logic std_video_model_disable;
  logic std_video_enable;
  logic platform_video_supported;
  logic zv_q;

  wire cfg = ~reg_space;
  wire hit_sys = cfg & (reg_addr[7:2] == 6'(`CSD_SYS_CTRL_OFF >> 2));
  wire hit_card_dw = cfg & (reg_addr[7:2] == 6'(`CSD_CARD_CTRL_OFF >> 2));
  wire hit_pres = reg_space & (reg_addr[7:2] == 6'(`CSD_PRESENT_OFF >> 2));
  wire hit_force = reg_space & (reg_addr[7:2] == 6'(`CSD_FORCE_OFF >> 2));
  wire hit_sctl = reg_space & (reg_addr[7:2] == 6'(`CSD_SOCK_CTRL_OFF >> 2));
  wire [7:0] cc_wbyte = reg_wdata[8*CC_LANE +: 8];
  wire [7:0] dg_wbyte = reg_wdata[8*DG_LANE +: 8];
  wire wr_sys = reg_wr & hit_sys & reg_be[`CSD_RING_OSC_BIT / 8];
  wire wr_cc = reg_wr & hit_card_dw & reg_be[CC_LANE];
  wire wr_dg = reg_wr & hit_card_dw & reg_be[DG_LANE];
  wire wr_force = reg_wr & hit_force & reg_be[`CSD_ZV_SUPPORT_BIT / 8];
  wire wr_sctl = reg_wr & hit_sctl & reg_be[`CSD_STD_ZV_EN_BIT / 8];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ring_osc_q <= `CSD_RING_OSC_RST;
      legacy_video_enable <= 1'b0;
      std_video_model_disable <= 1'b0;
      std_video_enable <= 1'b0;
      platform_video_supported <= 1'b0;
    end else begin
      if (wr_sys) begin
        ring_osc_q <= reg_wdata[`CSD_RING_OSC_BIT];
      end
      if (wr_cc) begin
        legacy_video_enable <= cc_wbyte[`CSD_LEGACY_ZV_BIT];
      end
      if (wr_dg) begin
        std_video_model_disable <= dg_wbyte[`CSD_STD_DIS_BIT];
      end
      if (wr_sctl) begin
        std_video_enable <= reg_wdata[`CSD_STD_ZV_EN_BIT];
      end
      if (wr_force && reg_wdata[`CSD_ZV_SUPPORT_BIT]) begin
        platform_video_supported <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zoomed video: either path enables it, the standard one only if allowed

  wire zv_d = legacy_video_enable |
              (~std_video_model_disable & std_video_enable);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      zv_q <= 1'b0;
    end else begin
      zv_q <= zv_d;
    end
  end

  assign card_addr_oe = {{22{~zv_q}}, 4'hF};
  assign video_switch_select_n = ~zv_q;
  assign video_path_status_out = zv_q;
  assign ring_osc_enable = ring_osc_q;

  ////////////////////////////////////////////////////////////////////////////
  // card status outputs

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      card_power_permit <= 1'b0;
      stschg_pullup_en <= 1'b0;
      stschg_pulldown_en <= 1'b0;
    end else begin
      card_power_permit <= (state_q == CSD_ST_DONE) && good_card;
      stschg_pullup_en <= (type_q == CSD_CARD_16BIT);
      stschg_pulldown_en <= (type_q == CSD_CARD_CARDBUS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] rd_sys;
  logic [31:0] rd_card;
  logic [31:0] rd_pres;
  logic [31:0] rd_sctl;
  logic [31:0] rd_mux;

  always_comb begin
    rd_sys = 32'h0000_0000;
    rd_sys[`CSD_RING_OSC_BIT] = ring_osc_q;
    rd_card = 32'h0000_0000;
    rd_card[8*CC_LANE + `CSD_LEGACY_ZV_BIT] = legacy_video_enable;
    rd_card[8*DG_LANE + `CSD_STD_DIS_BIT] = std_video_model_disable;
    rd_pres = 32'h0000_0000;
    rd_pres[`CSD_PS_CD_LSB +: 2] = pin_q[1:0];
    rd_pres[`CSD_PS_16BIT_BIT] = (type_q == CSD_CARD_16BIT);
    rd_pres[`CSD_PS_CB_BIT] = (type_q == CSD_CARD_CARDBUS);
    rd_pres[`CSD_PS_DONE_BIT] = (state_q == CSD_ST_DONE);
    rd_pres[`CSD_PS_BADCARD_BIT] = (type_q == CSD_CARD_UNKNOWN);
    rd_pres[`CSD_PS_VOLT_LSB +: 4] = volt_q;
    rd_pres[`CSD_ZV_SUPPORT_BIT] = platform_video_supported;
    rd_sctl = 32'h0000_0000;
    rd_sctl[`CSD_ZV_ACTIVE_BIT] = zv_q;
    rd_sctl[`CSD_STD_PRESENT_BIT] = ~std_video_model_disable;
    rd_sctl[`CSD_STD_ZV_EN_BIT] = std_video_enable;
  end

  assign rd_mux = hit_sys ? rd_sys :
                  hit_card_dw ? rd_card :
                  hit_pres ? rd_pres :
                  hit_sctl ? rd_sctl : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// [sim/csd_ctrl_properties.sv]
`timescale 1ns/1ps
module csd_ctrl_properties (
  // clock, reset and register strobes
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic reg_ack,
  // card side
  input wire logic voltage_sense_a_oe,
  input wire logic voltage_sense_b_oe,
  input wire logic card_power_permit,
  input wire logic stschg_pullup_en,
  input wire logic stschg_pulldown_en,
  // video and clocking
  input wire logic [25:0] card_addr_oe,
  input wire logic video_switch_select_n,
  input wire logic video_path_status_out,
  input wire logic ring_osc_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_after_req: assert property ((reg_rd || reg_wr) |=> reg_ack)
    else $error("no ack after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_rd || reg_wr))
    else $error("ack without request");
  a_low_addr_kept: assert property (card_addr_oe[3:0] == 4'hF)
    else $error("low address lines released");
  a_upper_addr_float: assert property (
    card_addr_oe[25:4] == {22{!video_path_status_out}})
    else $error("upper address drive wrong");
  a_select_matches: assert property (
    video_switch_select_n == !video_path_status_out)
    else $error("video select wrong");
  a_video_on_cause: assert property (
    $rose(video_path_status_out) |-> $past(reg_wr, 2))
    else $error("video on without write");
  a_power_not_probing: assert property (card_power_permit |->
    !voltage_sense_a_oe && !voltage_sense_b_oe)
    else $error("power during interrogation");
  a_pull_for_type: assert property (card_power_permit |->
    stschg_pullup_en != stschg_pulldown_en)
    else $error("status pin pull missing");
  a_pull_one_only: assert property (
    !(stschg_pullup_en && stschg_pulldown_en))
    else $error("pullup and pulldown both on");
  a_probe_in_order: assert property (
    $rose(voltage_sense_b_oe) |-> $past(voltage_sense_a_oe))
    else $error("sense b probed out of order");
  a_ring_off_cause: assert property ($fell(ring_osc_enable) |->
    $past(reg_wr && !reg_space && reg_be[3]))
    else $error("ring oscillator off without write");
endmodule

bind csd_ctrl csd_ctrl_properties csd_ctrl_properties_i (
  .sys_clk, .reset, .reg_space, .reg_wr, .reg_rd, .reg_be, .reg_ack,
  .voltage_sense_a_oe, .voltage_sense_b_oe, .card_power_permit,
  .stschg_pullup_en, .stschg_pulldown_en, .card_addr_oe,
  .video_switch_select_n, .video_path_status_out, .ring_osc_enable);

// [sim/csd_card_model.sv]
`timescale 1ns/1ps
module csd_card_model (
  // card choice
  input wire logic present,
  input wire logic [3:0] row,
  // device drive of sense pins
  input wire logic sense_a_oe,
  input wire logic sense_a_drv,
  input wire logic sense_b_oe,
  input wire logic sense_b_drv,
  // pin levels
  output logic card_detect_a,
  output logic card_detect_b,
  output logic sense_a,
  output logic sense_b
);
  // cfg: detect a source, detect b source (0 gnd 1 sense a 2 sense b 3 open),
  // sense a grounded, sense b grounded
  logic [5:0] cfg;
  always_comb begin
    case (present ? row : 4'hF)
      4'h0: cfg = 6'h00;
      4'h1: cfg = 6'h02;
      4'h2: cfg = 6'h03;
      4'h3: cfg = 6'h10;
      4'h4: cfg = 6'h0A;
      4'h5: cfg = 6'h05;
      4'h6: cfg = 6'h01;
      4'h7: cfg = 6'h08;
      4'h8: cfg = 6'h20;
      4'h9: cfg = 6'h04;
      4'hA: cfg = 6'h11;
      4'hB: cfg = 6'h22;
      default: cfg = 6'h3C;
    endcase
  end
  // open and strapped wires sit at the pull-up level
  assign sense_a = sense_a_oe ? sense_a_drv : !cfg[1];
  assign sense_b = sense_b_oe ? sense_b_drv : !cfg[0];
  assign card_detect_a = cfg[5:4] == 2'd0 ? 1'b0 : cfg[5:4] == 2'd1 ?
    sense_a : cfg[5:4] == 2'd2 ? sense_b : 1'b1;
  assign card_detect_b = cfg[3:2] == 2'd0 ? 1'b0 : cfg[3:2] == 2'd1 ?
    sense_a : cfg[3:2] == 2'd2 ? sense_b : 1'b1;
endmodule

// [sim/csd_ctrl_test.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++;\
 $display("BAD %s exp %h got %h", n, e, g); end end
module csd_ctrl_test;
  logic sys_clk = 0, reset = 1, reg_space = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0;
  logic [3:0] reg_be = 0, row = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rd_q;
  logic reg_ack, present = 0, cd_a, cd_b, vs_a, vs_b, a_out, a_oe, b_out, b_oe;
  logic permit, pu, pd, sel_n, zv_st, ring, on;
  logic [25:0] addr_oe;
  int error_cnt = 0, check_count = 0, seed = 75, i, k;

  csd_ctrl csd_ctrl_i (.sys_clk(sys_clk), .reset(reset),
    .reg_space(reg_space), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .card_detect_a(cd_a),
    .card_detect_b(cd_b), .voltage_sense_a_in(vs_a),
    .voltage_sense_a_out(a_out), .voltage_sense_a_oe(a_oe),
    .voltage_sense_b_in(vs_b), .voltage_sense_b_out(b_out),
    .voltage_sense_b_oe(b_oe), .card_power_permit(permit),
    .stschg_pullup_en(pu), .stschg_pulldown_en(pd), .card_addr_oe(addr_oe),
    .video_switch_select_n(sel_n), .video_path_status_out(zv_st),
    .ring_osc_enable(ring));
  csd_card_model csd_card_model_i (.present(present), .row(row),
    .sense_a_oe(a_oe), .sense_a_drv(a_out), .sense_b_oe(b_oe),
    .sense_b_drv(b_out), .card_detect_a(cd_a), .card_detect_b(cd_b),
    .sense_a(vs_a), .sense_b(vs_b));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one register access, ack due one cycle after the request
  task automatic acc(input logic sp, wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge sys_clk) #1;
    {reg_space, reg_addr, reg_be, reg_wdata} = {sp, a, be, d};
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge sys_clk) #1;
    reg_wr = 0;
    reg_rd = 0;
    `CHK("ack", 1'b1, reg_ack)
    rd_q = reg_rdata;
  endtask

  // present state: volts [13:10], unknown 7, done 6, cardbus 5, 16-bit 4
  function automatic logic [31:0] exp_ps(input logic [3:0] r);
    logic [6:0] c;
    case (r)
      0: c = 7'h09;
      1: c = 7'h19;
      2: c = 7'h39;
      3: c = 7'h12;
      4: c = 7'h32;
      5: c = 7'h72;
      6: c = 7'h21;
      7: c = 7'h22;
      8: c = 7'h62;
      9: c = 7'h42;
      default: c = 7'h04;
    endcase
    return {18'h0, c[6:3], 2'b00, c[2], 1'b1, c[1], c[0], 4'h0};
  endfunction

  // insert a card, interrogate or abort after ab cycles, then remove
  task automatic card(input logic [3:0] r, input int ab);
    logic [31:0] m, e;
    m = r > 9 ? 32'h00F0 : 32'h3CF0;
    e = exp_ps(r);
    @(posedge sys_clk) #1;
    row = r;
    present = 1;
    if (ab > 0) begin
      repeat (ab) @(posedge sys_clk);
      #1 present = 0;
    end else begin
      for (k = 0; k < 300; k++) begin
        acc(1, 0, 8'h08, 4'hF, 0);
        if (rd_q[6] === 1'b1) break;
      end
      `CHK("present", e & m, rd_q & m)
      if (rd_q[6] !== 1'b1) tally_and_finish;
      repeat (2) @(posedge sys_clk);
      #1 `CHK("permit", e[4] | e[5], permit)
      `CHK("pull", e[5:4], {pd, pu})
      acc(1, 0, 8'h10, 4'hF, 0);
      `CHK("model", 1'b0, rd_q[10])
      if (rd_q[10] === 1'b0) acc(0, 1, 8'h90, 4'h2, 32'h4000);
      present = 0;
    end
    repeat (8) @(posedge sys_clk);
    #1 `CHK("permit", 1'b0, permit)
    `CHK("probe", 2'b00, {a_oe, b_oe})
    $display("card row %0d abort %0d done", r, ab);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 reset = 0;
    `CHK("ring", 1'b1, ring)
    `CHK("addr_oe", 26'h3FFFFFF, addr_oe)
    `CHK("sel_n", 1'b1, sel_n)
    acc(0, 0, 8'h80, 4'hF, 0);
    `CHK("sysctl", 1'b1, rd_q[27])
    acc(1, 0, 8'h10, 4'hF, 0);
    `CHK("sockctl", 2'b01, rd_q[11:10])
    acc(1, 0, 8'h14, 4'hF, 32'hFFFFFFFF);
    `CHK("unmapped", 32'h0, rd_q)
    acc(0, 1, 8'h80, 4'h8, 0);
    `CHK("ring", 1'b0, ring)
    acc(0, 1, 8'h80, 4'h8, 32'h08000000);
    acc(1, 0, 8'h08, 4'hF, 0);
    `CHK("support", 1'b0, rd_q[27])
    acc(1, 1, 8'h0C, 4'hF, 32'h08000000);
    acc(1, 0, 8'h08, 4'hF, 0);
    `CHK("support", 1'b1, rd_q[27])
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      acc(0, 1, 8'h90, 4'hA, 0);
      acc(1, 1, 8'h10, 4'h2, 0);
      acc(1, 0, 8'h10, 4'hF, 0);
      `CHK("idle", 1'b0, rd_q[11])
      if (rd_q[11] === 1'b0) acc(1, 1, 8'h10, 4'h2, {22'h0, i[1], 9'h0});
      acc(0, 1, 8'h90, 4'hA, {7'h0, i[2], 9'h0, i[0], 14'h0});
      @(posedge sys_clk) #1;
      on = i[0] | (!i[2] & i[1]);
      `CHK("zv", on, zv_st)
      `CHK("addr_oe", {{22{!on}}, 4'hF}, addr_oe)
      `CHK("sel_n", !on, sel_n)
      acc(1, 0, 8'h10, 4'hF, 0);
      `CHK("sockctl", {on, !i[2], i[1]}, rd_q[11:9])
    end
    acc(0, 1, 8'h90, 4'h0, 0);
    acc(0, 0, 8'h90, 4'hF, 0);
    `CHK("lane", 1'b1, rd_q[14])
    $display("video test done");
    for (i = 0; i < 12; i++) card(i[3:0], 0);
    for (i = 0; i < 4; i++) card(4'(($random(seed) & 32'h7FFF) % 12), 0);
    card(4'h5, 150);
    tally_and_finish;
  end
endmodule
